/* File: verilog/panel_drive.sv */
`timescale 1ns/10ps
// Functional notes
// - sleep select: shut down or keep running
// - sleep shutdown: stop, ground pins, low current
// - enable clear finishes frame, then flags interrupt
// - after shutdown release pins to port use
// - core-clocked sleep without shutdown freezes pins
// - slow-clock sleep keeps refreshing from pixels
// - pixel data frozen during sleep
// - frame interrupt wakes device at boundary
// - unimplemented bits read zero
// - interrupt when active flag falls
// - frame interrupts only type-b non-static
module panel_drive (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [6:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [6:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               core_sleep,
  output panel_pkg::panel_pins_t  pins,
  output logic                    low_current,
  output logic                    wake_request,
  output logic                    irq
);
  import panel_pkg::*;

  // software visible registers
  logic [7:0]   ctrl;              // panel_control, pixel_write_error_flag kept apart
  logic         pixel_write_error_flag;              // pixel write error flag
  logic [7:0]   contrast;          // contrast control
  logic [7:0]   pix [0:7];         // pixel data, common-major
  logic [7:0]   prescale;          // wft, bias mode, frame prescale
  logic [7:0]   bias_ref;          // bias reference control
  logic [7:0]   bias_lad;          // bias ladder control
  logic [15:0]  seg_en;            // segment pin enables
  logic [1:0]   irq_stat;          // sticky events
  logic [1:0]   irq_mask;          // gates events onto irq

  // engine state
  drive_state_t state;             // drive sequencer
  logic         active;            // panel active flag
  logic [7:0]   tick_cnt;          // base tick divider
  logic         tick;              // one-cycle tick enable
  logic [4:0]   slice_cnt;         // slices within one common
  logic [3:0]   pre_cnt;           // frame prescale counter
  logic [1:0]   com_idx;           // current common
  logic         frame_end;         // last slice of the frame
  logic         running;           // frame engine advances
  logic         event_down;        // active falling, one cycle
  logic         event_frame;       // frame boundary event
  logic [1:0]   commons;           // multiplex setting, held in drain

  // bus handshake state
  logic         aw_held;           // write address captured
  logic         w_held;            // write data captured
  logic [6:0]   aw_addr;           // captured write address
  logic [7:0]   w_byte;            // captured low data byte
  logic         w_lane0;           // low byte lane enabled
  logic         do_write;          // commit pulse
  logic         rd_clears;         // status read side effect

  // decode of a bus address to pixel register index, shared by writes and reads
  function automatic logic [3:0] pix_index(input logic [6:0] a);
    if (a >= off_pix_c0_lo && a <= off_pix_c3_hi && a[1:0] == 2'h0)
      pix_index = {1'b0, 3'((a - off_pix_c0_lo) >> 2)};
    else
      pix_index = 4'h8;
  endfunction

  // frame interrupts exist only for type-b with a multiplexed setting
  wire frame_irq_legal = prescale[pos_wft] && (ctrl[1:0] != 2'h0);
  wire sleep_stop      = core_sleep && ctrl[pos_sleep_sel];
  wire fast_clk_sleep  = core_sleep && (ctrl[3:2] == src_core_div4);
  // updates during type-b non-static are only allowed right after a boundary
  wire write_window    = !frame_irq_legal || (com_idx == 2'h0 && slice_cnt < 5'h08);

  // base tick divider, stopped when the engine freezes
  // a stopped divider keeps its phase, so the pattern resumes in place
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= reset_value;
      tick     <= 1'b0;
    end else if (running) begin
      tick     <= (tick_cnt == tick_div);
      tick_cnt <= (tick_cnt == tick_div) ? reset_value : tick_cnt + 8'h01;
    end else begin
      tick     <= 1'b0; // frozen engine holds its last pattern
    end
  end

  // engine advances when driving and not frozen by sleep
  assign running = (state == st_run || state == st_drain) && !fast_clk_sleep;
  assign frame_end = tick && slice_cnt == slices_per_com && pre_cnt == prescale[3:0]
                     && com_idx == commons;

  // multiplex setting held through the drain at the value sampled on the edge that enters it
  // software clears the whole control byte at once, so that edge already sees the cleared
  // field and the final frame ends at the boundary set by the new multiplex setting
  always_ff @(posedge aclk) begin
    if (!aresetn)
      commons <= 2'h0;
    else if (state != st_drain)
      commons <= ctrl[1:0];
  end

  // slice, prescale and common counters
  // they restart from zero whenever the pins are not being driven
  always_ff @(posedge aclk) begin
    if (!aresetn || state == st_off || state == st_sleep_gnd) begin
      slice_cnt <= 5'h00;
      pre_cnt   <= 4'h0;
      com_idx   <= 2'h0;
    end else if (tick) begin
      if (slice_cnt != slices_per_com) begin
        slice_cnt <= slice_cnt + 5'h01;
      end else begin
        slice_cnt <= 5'h00;
        if (pre_cnt != prescale[3:0]) begin
          pre_cnt <= pre_cnt + 4'h1;
        end else begin
          pre_cnt <= 4'h0;
          com_idx <= (com_idx == commons) ? 2'h0 : com_idx + 2'h1;
        end
      end
    end
  end

  // drive sequencer
  // no default: all four codes are legal states
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_off;
    end else begin
      unique case (state)
        st_off: begin
          if (sleep_stop)
            state <= st_sleep_gnd;
          else if (ctrl[pos_enable])
            state <= st_run;
        end
        st_run: begin
          if (sleep_stop)
            state <= st_sleep_gnd;
          else if (!ctrl[pos_enable])
            state <= st_drain;
        end
        st_drain: begin
          if (sleep_stop)
            state <= st_sleep_gnd;
          else if (ctrl[pos_enable])
            state <= st_run;
          else if (frame_end)
            state <= st_off;
        end
        st_sleep_gnd: begin
          if (!core_sleep)
            state <= ctrl[pos_enable] ? st_run : st_off;
        end
      endcase
    end
  end

  // active flag follows the framing states
  // it drops one cycle after the drain ends, the shutdown event with it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active     <= 1'b0;
      event_down <= 1'b0;
    end else begin
      active     <= (state == st_run || state == st_drain);
      event_down <= active && !(state == st_run || state == st_drain);
    end
  end

  // frame boundary event
  // only multiplexed type-b frames raise it
  always_ff @(posedge aclk) begin
    if (!aresetn)
      event_frame <= 1'b0;
    else
      event_frame <= frame_end && frame_irq_legal;
  end

  // pin drive, one process per concern
  // enables travel with the pattern so pads switch together with their data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins        <= '0;
      low_current <= 1'b0;
    end else begin
      low_current <= (state == st_sleep_gnd);
      if (state == st_sleep_gnd) begin
        pins.com        <= 4'h0;
        pins.seg        <= 16'h0000;
        pins.seg_en     <= seg_en;
        pins.pins_owned <= 1'b1;
      end else if (state == st_off) begin
        pins <= '0;
      end else if (running) begin
        // simple phase drive, inverted on odd prescale steps for dc balance
        pins.com        <= 4'(4'h1 << com_idx) ^ {4{pre_cnt[0]}};
        pins.seg        <= {pix[{com_idx, 1'b1}], pix[{com_idx, 1'b0}]} ^ {16{pre_cnt[0]}};
        pins.seg_en     <= seg_en;
        pins.pins_owned <= 1'b1;
      end
    end
  end

  // wake request on frame boundary while asleep
  // a single pulse; whoever wakes the core must latch it
  always_ff @(posedge aclk) begin
    if (!aresetn)
      wake_request <= 1'b0;
    else
      wake_request <= core_sleep && event_frame && irq_mask[irq_frame];
  end

  // sticky status, set beats the read clear
  // an event in the clearing cycle survives for the next read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (rd_clears ? 2'h0 : irq_stat) | {event_frame, event_down};
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // write channel capture, either order
  // the commit waits until both address and data are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 7'h00;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held;

  // write response
  // misaligned or out-of-range writes answer with an error and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr > off_irq_mask || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; pixel writes blocked in sleep or outside the window
  // a refused pixel write sets the error flag instead of landing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= reset_value;
      pixel_write_error_flag     <= 1'b0;
      contrast <= reset_value;
      prescale <= reset_value;
      bias_ref <= reset_value;
      bias_lad <= reset_value;
      seg_en   <= 16'h0000;
      irq_mask <= 2'h0;
      for (int i = 0; i < 8; i++)
        pix[i] <= reset_value;
    end else if (do_write && w_lane0) begin
      unique case (aw_addr)
        off_panel_control: begin
          ctrl <= w_byte & mask_panel_control & ~8'h20;
          pixel_write_error_flag <= pixel_write_error_flag & w_byte[pos_pixel_write_error_flag]; // cleared by writing zero
        end
        off_contrast_control: contrast <= w_byte & mask_contrast;
        off_phase_prescale:   prescale <= w_byte & mask_prescale_rw;
        off_bias_reference:   bias_ref <= w_byte & mask_bias_reference;
        off_bias_ladder:      bias_lad <= w_byte & mask_bias_ladder;
        off_seg_enable_lo:    seg_en[7:0]  <= w_byte;
        off_seg_enable_hi:    seg_en[15:8] <= w_byte;
        off_irq_mask:         irq_mask <= w_byte[1:0];
        default: begin
          if (pix_index(aw_addr) != 4'h8) begin
            if (core_sleep || (active && !write_window))
              pixel_write_error_flag <= 1'b1;
            else
              pix[pix_index(aw_addr)[2:0]] <= w_byte;
          end
        end
      endcase
    end
  end

  // read channel with status clear on read
  // status clears only when the read is accepted, so a stalled read loses nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h0000_0000;
      unique case (s_axi_araddr)
        off_panel_control:    s_axi_rdata[7:0] <= ctrl | {2'h0, pixel_write_error_flag, 5'h00};
        off_contrast_control: s_axi_rdata[7:0] <= contrast;
        off_phase_prescale:
          s_axi_rdata[7:0] <= prescale | {2'h0, active, write_window, 4'h0};
        off_bias_reference:   s_axi_rdata[7:0] <= bias_ref;
        off_bias_ladder:      s_axi_rdata[7:0] <= bias_lad;
        off_seg_enable_lo:    s_axi_rdata[7:0] <= seg_en[7:0];
        off_seg_enable_hi:    s_axi_rdata[7:0] <= seg_en[15:8];
        off_irq_status:       s_axi_rdata[1:0] <= irq_stat;
        off_irq_mask:         s_axi_rdata[1:0] <= irq_mask;
        default: begin
          if (pix_index(s_axi_araddr) != 4'h8)
            s_axi_rdata[7:0] <= pix[pix_index(s_axi_araddr)[2:0]];
          else
            s_axi_rresp <= 2'h2; // unmapped
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_clears     = s_axi_arvalid && s_axi_arready && s_axi_araddr == off_irq_status;

endmodule // panel_drive

/* File: verilog/panel_pkg.sv */
package panel_pkg;

  // register byte offsets on the bus, one aligned word each
  localparam logic [6:0] off_panel_control     = 7'h00;
  localparam logic [6:0] off_contrast_control  = 7'h04;
  localparam logic [6:0] off_pix_c0_lo         = 7'h08;
  localparam logic [6:0] off_pix_c0_hi         = 7'h0c;
  localparam logic [6:0] off_pix_c1_lo         = 7'h10;
  localparam logic [6:0] off_pix_c1_hi         = 7'h14;
  localparam logic [6:0] off_pix_c2_lo         = 7'h18;
  localparam logic [6:0] off_pix_c2_hi         = 7'h1c;
  localparam logic [6:0] off_pix_c3_lo         = 7'h20;
  localparam logic [6:0] off_pix_c3_hi         = 7'h24;
  localparam logic [6:0] off_phase_prescale    = 7'h28;
  localparam logic [6:0] off_bias_reference    = 7'h2c;
  localparam logic [6:0] off_bias_ladder       = 7'h30;
  localparam logic [6:0] off_seg_enable_lo     = 7'h34;
  localparam logic [6:0] off_seg_enable_hi     = 7'h38;
  localparam logic [6:0] off_irq_status        = 7'h3c;
  localparam logic [6:0] off_irq_mask          = 7'h40;

  // panel_control fields
  localparam int pos_enable    = 7;
  localparam int pos_sleep_sel = 6;
  localparam int pos_pixel_write_error_flag      = 5;
  localparam logic [7:0] mask_panel_control   = 8'hef;
  localparam logic [7:0] mask_contrast        = 8'h07;
  localparam logic [7:0] mask_bias_reference  = 8'he6;
  localparam logic [7:0] mask_bias_ladder     = 8'hf7;
  // phase_prescale fields
  localparam int pos_wft    = 7;
  localparam int pos_active = 5;
  localparam int pos_wa     = 4;
  localparam logic [7:0] mask_prescale_rw = 8'hcf;

  // clock source codes in panel_control[3:2]
  localparam logic [1:0] src_core_div4 = 2'h0;
  localparam logic [1:0] src_crystal   = 2'h1;
  localparam logic [1:0] src_internal  = 2'h2;

  // status bit positions
  localparam int irq_shutdown = 0;
  localparam int irq_frame    = 1;

  // timing: base tick divider and slices per common
  localparam logic [7:0] tick_div      = 8'h1f;
  localparam logic [4:0] slices_per_com = 5'h1f;
  localparam logic [7:0] reset_value   = 8'h00;

  // pad drive towards the glass
  typedef struct packed {
    logic [3:0]  com;
    logic [15:0] seg;
    logic [15:0] seg_en;
    logic        pins_owned;
  } panel_pins_t;

  typedef enum logic [1:0] {
    st_off      = 2'b00,
    st_run      = 2'b01,
    st_drain    = 2'b11,
    st_sleep_gnd = 2'b10
  } drive_state_t;

endpackage

/* File: verif/panel_drive_properties.sv */
`timescale 1ns/10ps
module panel_drive_properties
  import panel_pkg::*;
(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   core_sleep,
  input wire panel_pins_t            pins,
  input wire logic                   low_current,
  input wire logic                   wake_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and data taken at one edge
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer_time: assert property (write_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_read_answer_time: assert property (read_taken |=> s_axi_rvalid)
    else $error("read response not on time");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_upper_bits_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  a_ground_in_sleep: assert property (
    low_current |-> pins.com == 4'h0 && pins.seg == 16'h0) else $error("pins not grounded");
  a_low_needs_sleep: assert property (low_current |-> $past(core_sleep, 2))
    else $error("low current outside sleep");
  a_wake_while_asleep: assert property (wake_request |-> $past(core_sleep))
    else $error("wake without sleep");
  a_wake_one_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake longer than a pulse");
endmodule // panel_drive_properties

bind panel_drive panel_drive_properties chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .core_sleep(core_sleep), .pins(pins), .low_current(low_current),
  .wake_request(wake_request)
);

/* File: verif/panel_glass.sv */
`timescale 1ns/10ps
module panel_glass
  import panel_pkg::*;
(
  input wire logic        aclk,
  input wire panel_pins_t pins,
  output int              com_edges
);
  logic [3:0] last_com;  // previous common pattern
  int         count = 0; // common changes seen so far
  // the glass only feels a refresh as a common change; counted for the bench
  assign com_edges = count;
  always @(posedge aclk) begin
    last_com <= pins.com;
    if (pins.com !== last_com) count <= count + 1;
  end
endmodule // panel_glass

/* File: verif/panel_drive_tb_top.sv */
`timescale 1ns/10ps
module panel_drive_tb_top;
  import panel_pkg::*;
  logic [6:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, core_sleep, low_current, wake, irq;
  panel_pins_t pins;
  int          miscompares, total_checks, com_edges, e, n;
  panel_drive dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_sleep(core_sleep), .pins(pins),
    .low_current(low_current), .wake_request(wake), .irq(irq));
  panel_glass glass (.aclk(aclk), .pins(pins), .com_edges(com_edges));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a wait that ran out ends the run as a failure
  task automatic give_up;
    miscompares++;
    $display("wait limit reached");
    tally_and_finish();
  endtask
  // one write; idle edge first so bready is never driven twice in a step
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 50) give_up();
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] rs);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (k == 50) give_up();
  endtask
  // reset values, masked read-back, unmapped place
  task automatic t_map;
    logic [6:0] ad [3] = '{off_contrast_control, off_bias_reference, off_bias_ladder};
    logic [7:0] mk [3] = '{mask_contrast, mask_bias_reference, mask_bias_ladder};
    rd(off_panel_control, v, r);
    chk("control reset", v, {24'h0, reset_value});
    for (int i = 0; i < 3; i++) begin
      wr(ad[i], 8'hff);
      rd(ad[i], v, r);
      chk("masked reg", v, {24'h0, mk[i]});
    end
    rd(7'h44, v, r);
    chk("unmapped resp", r, 2'h2);
    $display("map test done");
  endtask
  // run from the crystal, sleep without shutdown, wake on frame
  task automatic t_keep_running;
    wr(off_phase_prescale, 8'h80);
    wr(off_seg_enable_lo, 8'hff);
    wr(off_seg_enable_hi, 8'hff);
    wr(off_panel_control, 8'h05);
    wr(off_pix_c0_lo, 8'ha5);
    rd(off_irq_status, v, r);
    wr(off_irq_mask, 8'h02);
    wr(off_panel_control, 8'h85);
    rd(off_phase_prescale, v, r);
    chk("active flag", v[pos_active], 1'b1);
    chk("pins owned", pins.pins_owned, 1'b1);
    chk("segment enables", pins.seg_en, 16'hffff);
    chk("segment data", pins.seg, 16'h00a5);
    core_sleep <= 1'b1;
    e = com_edges;
    wr(off_pix_c0_lo, 8'h00);
    for (n = 0; n < 5000 && !wake; n++) @(posedge aclk);
    if (n == 5000) give_up();
    chk("refresh in sleep", com_edges > e, 1'b1);
    core_sleep <= 1'b0;
    rd(off_panel_control, v, r);
    chk("write error", v[pos_pixel_write_error_flag], 1'b1);
    rd(off_pix_c0_lo, v, r);
    chk("pixel kept", v, 32'ha5);
    chk("frame irq", irq, 1'b1);
    wr(off_irq_mask, 8'h00);
    repeat (3) @(posedge aclk);
    chk("masked irq", irq, 1'b0);
    $display("keep running test done");
  endtask
  // orderly shutdown at frame end
  task automatic t_shutdown;
    wr(off_irq_mask, 8'h01);
    rd(off_irq_status, v, r);
    wr(off_panel_control, 8'h00);
    rd(off_phase_prescale, v, r);
    chk("active in drain", v[pos_active], 1'b1);
    chk("drive to frame end", pins.pins_owned, 1'b1);
    v = 32'h20;
    for (n = 0; n < 1000 && v[pos_active]; n++) rd(off_phase_prescale, v, r);
    if (n == 1000) give_up();
    repeat (3) @(posedge aclk);
    chk("pins released", pins.pins_owned, 1'b0);
    chk("shutdown irq", irq, 1'b1);
    rd(off_irq_status, v, r);
    chk("shutdown status", v[irq_shutdown], 1'b1);
    repeat (3) @(posedge aclk);
    chk("irq cleared", irq, 1'b0);
    $display("shutdown test done");
  endtask
  // sleep with shutdown selected, then core clock freeze
  task automatic t_sleep_modes;
    logic [19:0] p;
    wr(off_phase_prescale, 8'h00); // type-a waveform
    wr(off_panel_control, 8'hc5);
    repeat (2100) @(posedge aclk);
    rd(off_irq_status, v, r);
    chk("no type-a frame irq", v[irq_frame], 1'b0);
    core_sleep <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("low current", low_current, 1'b1);
    chk("grounded", {pins.com, pins.seg}, 20'h0);
    core_sleep <= 1'b0;
    wr(off_panel_control, 8'h81);
    repeat (40) @(posedge aclk);
    core_sleep <= 1'b1;
    repeat (3) @(posedge aclk);
    p = {pins.com, pins.seg};
    e = com_edges;
    repeat (1100) @(posedge aclk);
    chk("frozen pins", {pins.com, pins.seg}, p);
    chk("no refresh", com_edges, e);
    chk("no low current", low_current, 1'b0);
    core_sleep <= 1'b0;
    $display("sleep modes test done");
  endtask
  initial begin
    miscompares = 0;
    total_checks = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, core_sleep} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_map();
    t_keep_running();
    t_shutdown();
    t_sleep_modes();
    tally_and_finish();
  end
endmodule // panel_drive_tb_top
